// *** include/pbc_pkg.sv ***
package pbc_pkg;

  // Configuration dword index of the command/status dword (byte offset 0x04).
  localparam logic [5:0] PBC_CMD_DWORD = 6'h01;

  // Field positions inside the 16-bit command half of the dword.
  localparam int PBC_IO_EN_BIT = 0;
  localparam int PBC_MEM_EN_BIT = 1;
  localparam int PBC_MASTER_EN_BIT = 2;
  localparam int PBC_SPECIAL_EN_BIT = 3;
  localparam int PBC_MWI_EN_BIT = 4;

  // Reset values of the fields and of the whole command half.
  localparam logic PBC_IO_EN_RST = 1'b0;
  localparam logic PBC_MEM_EN_RST = 1'b0;
  localparam logic PBC_MASTER_EN_RST = 1'b0;
  localparam logic [15:0] PBC_CMD_RST = 16'h0000;

  // Read-only fields and the upper status half, which live outside this block.
  localparam logic PBC_RO_ZERO = 1'b0;
  localparam logic [15:0] PBC_STATUS_ZERO = 16'h0000;
  localparam logic [31:0] PBC_DWORD_ZERO = 32'h0000_0000;

  // Transaction class as seen by the decoders around the bridge core.
  typedef enum logic [2:0] {
    PBC_KIND_NONE = 3'h0,
    PBC_KIND_IO = 3'h1,
    PBC_KIND_MEM = 3'h3,
    PBC_KIND_CFG = 3'h2,
    PBC_KIND_SPECIAL = 3'h6
  } pbc_kind_e;

  // One configuration access taken from the primary bus.
  typedef struct packed {
    logic valid;
    logic write;
    logic type0;
    logic [5:0] dword;
    logic [3:0] be_n;
    logic [31:0] wdata;
  } pbc_cfg_req_s;

  // One transaction offered for claiming or for forwarding.
  typedef struct packed {
    logic valid;
    pbc_kind_e kind;
    logic in_range;
    logic mem_write;
    logic orig_mwi;
  } pbc_txn_s;

  // Decoded command fields handed to the rest of the bridge.
  typedef struct packed {
    logic mwi_en;
    logic special_en;
    logic master_en;
    logic mem_en;
    logic io_en;
  } pbc_cmd_s;

endpackage : pbc_pkg

// *** core/pbc_primary_command.sv ***
`timescale 1ns/100ps
// Functional notes
// - I/O enable clear: no primary I/O claim
// - I/O enable set: primary I/O responses allowed
// - Memory enable clear: no primary memory claim
// - Memory enable set: claim decoded memory ranges
// - Master enable clear: block secondary I/O/memory
// - Master enable set: initiate primary, claim secondary
// - Configuration forwarding ignores master enable
// - Special cycles ignored; enable reads zero
// - MWI enable reads zero; forward-only MWI
// - Command fields govern the primary interface
module pbc_primary_command
  import pbc_pkg::*;
(
  input wire logic i_sys_clk, // Primary bus clock.
  input wire logic i_rst_b, // Asynchronous reset, active low.
  input wire pbc_cfg_req_s i_cfg, // Configuration access from the primary bus.
  output logic o_cfg_hit, // Access addresses the command dword.
  output logic o_cfg_ack, // One-cycle completion of a taken access.
  output logic [31:0] o_cfg_rdata, // Read data, valid with o_cfg_ack.
  input wire pbc_txn_s i_p_txn, // Transaction started on the primary bus.
  output logic o_p_claim, // Bridge claims the primary transaction.
  input wire pbc_txn_s i_s_txn, // Transaction started on the secondary bus.
  output logic o_s_claim, // Bridge claims the secondary transaction.
  input wire pbc_txn_s i_fwd_txn, // Request to initiate on the primary bus.
  output logic o_fwd_grant, // Primary initiation permitted.
  output logic o_fwd_use_mwi, // Issue memory write and invalidate.
  output pbc_cmd_s o_cmd // Current command fields.
);

  logic io_en_reg;
  logic mem_en_reg;
  logic master_en_reg;
  logic io_en_next;
  logic mem_en_next;
  logic master_en_next;
  logic cfg_take;
  logic cfg_write;
  logic low_lane_on;
  logic ack_reg;
  logic [31:0] rdata_reg;
  logic [15:0] cmd_view;

  // Memory, I/O and configuration claims all depend on the range decode.
  function automatic logic gate_kind(
    input pbc_txn_s txn,
    input logic io_ok,
    input logic mem_ok
  );
    logic ok;
    ok = 1'b0;
    if (txn.valid) begin
      unique case (txn.kind)
        PBC_KIND_IO: ok = io_ok & txn.in_range;
        PBC_KIND_MEM: ok = mem_ok & txn.in_range;
        // Configuration forwarding passes whenever in range, whatever the enables.
        PBC_KIND_CFG: ok = txn.in_range;
        // Special cycles ignored.
        PBC_KIND_SPECIAL: ok = 1'b0;
        PBC_KIND_NONE: ok = 1'b0;
        default: ok = 1'b0;
      endcase
    end
    return ok;
  endfunction : gate_kind

  assign o_cfg_hit = i_cfg.valid & i_cfg.type0 & (i_cfg.dword == PBC_CMD_DWORD);
  assign cfg_take = o_cfg_hit;
  assign cfg_write = cfg_take & i_cfg.write;
  assign low_lane_on = ~i_cfg.be_n[0];

  // The writable fields all sit in byte lane 0; lane 1 holds nothing here.
  always_comb begin
    io_en_next = io_en_reg;
    mem_en_next = mem_en_reg;
    master_en_next = master_en_reg;
    if (cfg_write && low_lane_on) begin
      io_en_next = i_cfg.wdata[PBC_IO_EN_BIT];
      mem_en_next = i_cfg.wdata[PBC_MEM_EN_BIT];
      master_en_next = i_cfg.wdata[PBC_MASTER_EN_BIT];
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      io_en_reg <= PBC_IO_EN_RST;
    end else begin
      io_en_reg <= io_en_next;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      mem_en_reg <= PBC_MEM_EN_RST;
    end else begin
      mem_en_reg <= mem_en_next;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      master_en_reg <= PBC_MASTER_EN_RST;
    end else begin
      master_en_reg <= master_en_next;
    end
  end

  always_comb begin
    cmd_view = PBC_CMD_RST;
    cmd_view[PBC_IO_EN_BIT] = io_en_reg;
    cmd_view[PBC_MEM_EN_BIT] = mem_en_reg;
    cmd_view[PBC_MASTER_EN_BIT] = master_en_reg;
    cmd_view[PBC_SPECIAL_EN_BIT] = PBC_RO_ZERO;
    cmd_view[PBC_MWI_EN_BIT] = PBC_RO_ZERO;
  end

  // Reads return the whole dword; the master picks its lanes from it.
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ack_reg <= 1'b0;
      rdata_reg <= PBC_DWORD_ZERO;
    end else begin
      ack_reg <= cfg_take;
      if (cfg_take && !i_cfg.write) begin
        rdata_reg <= {PBC_STATUS_ZERO, cmd_view};
      end else begin
        rdata_reg <= PBC_DWORD_ZERO;
      end
    end
  end

  assign o_cfg_ack = ack_reg;

  assign o_cfg_rdata = rdata_reg;

  // Each claim path has its own enables so that retuning one path cannot
  // silently change the behaviour of the others.
  logic p_io_ok;

  logic p_mem_ok;

  logic s_io_ok;

  logic s_mem_ok;

  logic f_io_ok;

  logic f_mem_ok;

  logic p_claim_w;

  logic s_claim_w;

  logic fwd_grant_w;

  logic fwd_is_mem;

  logic fwd_is_write;

  logic fwd_from_mwi;

  logic fwd_mwi_w;

  always_comb begin
    p_io_ok = io_en_reg;

    p_mem_ok = mem_en_reg;
  end

  always_comb begin
    s_io_ok = master_en_reg;

    s_mem_ok = master_en_reg;
  end

  always_comb begin
    f_io_ok = master_en_reg;

    f_mem_ok = master_en_reg;
  end

  always_comb begin
    p_claim_w = gate_kind(i_p_txn, p_io_ok, p_mem_ok);
  end

  always_comb begin
    s_claim_w = gate_kind(i_s_txn, s_io_ok, s_mem_ok);
  end

  always_comb begin
    fwd_grant_w = gate_kind(i_fwd_txn, f_io_ok, f_mem_ok);
  end

  assign o_p_claim = p_claim_w;

  assign o_s_claim = s_claim_w;

  assign o_fwd_grant = fwd_grant_w;

  // The bridge never originates this command; it only passes one along.
  always_comb begin
    fwd_is_mem = 1'b0;

    fwd_is_write = 1'b0;

    fwd_from_mwi = 1'b0;

    if (i_fwd_txn.kind == PBC_KIND_MEM) begin
      fwd_is_mem = 1'b1;
    end

    if (i_fwd_txn.mem_write) begin
      fwd_is_write = 1'b1;
    end

    if (i_fwd_txn.orig_mwi) begin
      fwd_from_mwi = 1'b1;
    end
  end

  always_comb begin
    fwd_mwi_w = 1'b0;

    if (fwd_grant_w && fwd_is_mem) begin
      fwd_mwi_w = fwd_is_write & fwd_from_mwi;
    end
  end

  assign o_fwd_use_mwi = fwd_mwi_w;

  // The decoded fields follow the stored bits; read-only ones stay zero.
  always_comb begin
    o_cmd.io_en = io_en_reg;

    o_cmd.mem_en = mem_en_reg;

    o_cmd.master_en = master_en_reg;

    o_cmd.special_en = PBC_RO_ZERO;

    o_cmd.mwi_en = PBC_RO_ZERO;
  end

endmodule : pbc_primary_command

// *** sim/pbc_primary_command_checker.sv ***
`timescale 1ns/100ps
module pbc_cmd_checker
  import pbc_pkg::*;
(
  input wire logic i_sys_clk, // Clock.
  input wire logic i_rst_b, // Reset.
  input wire pbc_cfg_req_s i_cfg, // Access.
  input wire logic o_cfg_hit, // Hit.
  input wire logic o_cfg_ack, // Ack.
  input wire logic [31:0] o_cfg_rdata, // Data.
  input wire pbc_txn_s i_p_txn, // Primary.
  input wire logic o_p_claim, // Claim.
  input wire pbc_txn_s i_s_txn, // Secondary.
  input wire logic o_s_claim, // Claim.
  input wire pbc_txn_s i_fwd_txn, // Forward.
  input wire logic o_fwd_grant, // Grant.
  input wire logic o_fwd_use_mwi, // Mwi.
  input wire pbc_cmd_s o_cmd // Fields.
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);
  io_off_a: assert property (i_p_txn.kind == PBC_KIND_IO && !o_cmd.io_en |-> !o_p_claim)
    else $error("io claim");
  mem_claim_a: assert property (i_p_txn.kind == PBC_KIND_MEM
    |-> o_p_claim == (i_p_txn.valid && o_cmd.mem_en && i_p_txn.in_range)) else $error("mem");
  sec_io_a: assert property (i_s_txn.kind == PBC_KIND_IO
    |-> o_s_claim == (i_s_txn.valid && o_cmd.master_en && i_s_txn.in_range)) else $error("sec");
  fwd_off_a: assert property (!o_cmd.master_en && i_fwd_txn.kind != PBC_KIND_CFG
    |-> !o_fwd_grant) else $error("fwd");
  cfg_fwd_a: assert property (i_fwd_txn.kind == PBC_KIND_CFG
    |-> o_fwd_grant == (i_fwd_txn.valid && i_fwd_txn.in_range)) else $error("cfg");
  special_a: assert property (i_p_txn.kind == PBC_KIND_SPECIAL |-> !o_p_claim)
    else $error("special");
  mwi_only_a: assert property (o_fwd_use_mwi |-> i_fwd_txn.orig_mwi && o_fwd_grant)
    else $error("mwi");
  ro_zero_a: assert property (!o_cmd.special_en && !o_cmd.mwi_en && !(|o_cfg_rdata[31:3]))
    else $error("ro");
  hit_ack_a: assert property (o_cfg_hit |=> o_cfg_ack)
    else $error("no ack after hit");
  miss_quiet_a: assert property (!o_cfg_hit |=> !o_cfg_ack)
    else $error("ack without hit");
endmodule : pbc_cmd_checker
bind pbc_primary_command pbc_cmd_checker chk_u (.i_sys_clk, .i_rst_b, .i_cfg, .o_cfg_hit,
  .o_cfg_ack, .o_cfg_rdata, .i_p_txn, .o_p_claim, .i_s_txn, .o_s_claim, .i_fwd_txn,
  .o_fwd_grant, .o_fwd_use_mwi, .o_cmd);

// *** sim/pbc_host_model.sv ***
`timescale 1ns/100ps
module pbc_host_model
  import pbc_pkg::*;
(
  input wire logic i_sys_clk, // Clock.
  input wire logic i_ack, // Ack.
  input wire logic [31:0] i_rdata, // Data.
  output pbc_cfg_req_s o_cfg // Access.
);
  initial o_cfg = '0;
  task automatic access(input logic wr, input logic [5:0] dw, input logic [3:0] be_n,
      input logic [31:0] wd, output logic ack, output logic [31:0] rd);
    @(posedge i_sys_clk);
    o_cfg <= {1'b1, wr, 1'b1, dw, be_n, wd};
    @(posedge i_sys_clk);
    // Released lines flip so stale data never passes for a fresh request.
    o_cfg <= {1'b0, ~o_cfg[43:0]};
    // Answer is settled mid-cycle; sampling on the launch edge would race it.
    @(negedge i_sys_clk);
    ack = i_ack;
    rd = i_rdata;
  endtask : access
endmodule : pbc_host_model

// *** sim/test_bridge_primary_command_bits.sv ***
`timescale 1ns/100ps
module test_bridge_primary_command_bits;
  import pbc_pkg::*;
  logic i_sys_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic o_cfg_hit, o_cfg_ack, o_p_claim, o_s_claim, o_fwd_grant, o_fwd_use_mwi, ack;
  logic [31:0] o_cfg_rdata, rd;
  pbc_cfg_req_s i_cfg;
  pbc_txn_s i_p_txn = '0, i_s_txn = '0, i_fwd_txn = '0;
  pbc_cmd_s o_cmd;
  int mismatches = 0, checks_done = 0, cyc = 0;
  always #5 i_sys_clk = ~i_sys_clk;
  always @(posedge i_sys_clk) if (++cyc == 2000) begin mismatches++; close_out(); end
  pbc_primary_command dut_u (.i_sys_clk, .i_rst_b, .i_cfg, .o_cfg_hit, .o_cfg_ack, .o_cfg_rdata,
    .i_p_txn, .o_p_claim, .i_s_txn, .o_s_claim, .i_fwd_txn, .o_fwd_grant, .o_fwd_use_mwi, .o_cmd);
  pbc_host_model host_u (.i_sys_clk, .i_ack(o_cfg_ack), .i_rdata(o_cfg_rdata), .o_cfg(i_cfg));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic close_out();
    $display("checks_done=%0d mismatches=%0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : close_out
  task automatic acc(input logic wr, input logic [5:0] dw, input logic [3:0] be_n,
      input logic [31:0] wd);
    host_u.access(wr, dw, be_n, wd, ack, rd);
    chk(ack, dw == PBC_CMD_DWORD);
  endtask : acc
  task automatic t_txn(input logic io, input logic mem, input logic ms);
    pbc_kind_e kl[5] = '{PBC_KIND_NONE, PBC_KIND_IO, PBC_KIND_CFG, PBC_KIND_MEM, PBC_KIND_SPECIAL};
    logic pe, se;
    foreach (kl[i]) begin
      @(posedge i_sys_clk);
      i_p_txn <= {1'b1, kl[i], 3'h7};
      i_s_txn <= {1'b1, kl[i], 3'h7};
      i_fwd_txn <= {1'b1, kl[i], 3'h7};
      @(negedge i_sys_clk);
      pe = kl[i] == PBC_KIND_IO ? io : kl[i] == PBC_KIND_MEM ? mem : kl[i] == PBC_KIND_CFG;
      se = kl[i] inside {PBC_KIND_IO, PBC_KIND_MEM} ? ms : kl[i] == PBC_KIND_CFG;
      chk(o_p_claim, pe);
      chk(o_s_claim, se);
      chk(o_fwd_grant, se);
      chk(o_fwd_use_mwi, se && kl[i] == PBC_KIND_MEM);
    end
  endtask : t_txn
  task automatic t_reset();
    acc(1'h0, PBC_CMD_DWORD, 4'h0, 32'h0);
    chk(rd, PBC_DWORD_ZERO);
    t_txn(1'h0, 1'h0, 1'h0);
  endtask : t_reset
  task automatic t_ro_write();
    acc(1'h1, PBC_CMD_DWORD, 4'h0, 32'hFFFF_FFFF);
    acc(1'h0, PBC_CMD_DWORD, 4'h0, 32'h0);
    chk(rd, 32'h0000_0007);
    chk(o_cmd, 5'h07);
    t_txn(1'h1, 1'h1, 1'h1);
    acc(1'h1, PBC_CMD_DWORD, 4'h1, 32'h0);
    acc(1'h0, PBC_CMD_DWORD, 4'h0, 32'h0);
    chk(rd, 32'h0000_0007);
  endtask : t_ro_write
  task automatic t_master_off();
    acc(1'h1, PBC_CMD_DWORD, 4'h0, 32'h0000_0002);
    t_txn(1'h0, 1'h1, 1'h0);
    acc(1'h0, 6'h02, 4'h0, 32'h0);
  endtask : t_master_off
  initial begin
    repeat (6) @(posedge i_sys_clk);
    i_rst_b <= 1'b1;
    t_reset();
    t_ro_write();
    t_master_off();
    close_out();
  end
endmodule : test_bridge_primary_command_bits
